// ---- src/aos_defs.svh ----
// Offsets, field positions, reset values and timing counts of the output sequencer.
`ifndef AOS_DEFS_SVH
`define AOS_DEFS_SVH
`define AOS_OFF_CTRL      12'h000
`define AOS_OFF_LIST      12'h004
`define AOS_OFF_DIV       12'h008
`define AOS_OFF_DATA      12'h00c
`define AOS_OFF_STAT      12'h010
`define AOS_OFF_MASK      12'h014
`define AOS_OFF_CMD       12'h018
`define AOS_OFF_OUT       12'h01c
`define AOS_CTRL_CONT     0
`define AOS_CTRL_EXTCLK   1
`define AOS_CTRL_TRG_LO   2
`define AOS_CTRL_TRG_HI   3
`define AOS_CMD_START     0
`define AOS_CMD_STOP      1
`define AOS_ST_UNDER      0
`define AOS_ST_OVERS      1
`define AOS_ST_RUN        2
`define AOS_CH_ZERO       2'h0
`define AOS_CH_ONE        2'h1
`define AOS_CH_DIG        2'h2
`define AOS_GAIN_ONE      1
`define AOS_CLK_HZ        50000000
`define AOS_MAX_RATE_SPS  150000
`define AOS_MIN_DIV       ((`AOS_CLK_HZ + `AOS_MAX_RATE_SPS - 1) / `AOS_MAX_RATE_SPS)
`define AOS_DIV_RESET     32'h0000014e
`define AOS_LOAD_CYCLES   3
`define AOS_QDEPTH        4
`endif

// ---- src/aos_pkg.sv ----
// Types shared by the output sequencer.
package aos_pkg;
	typedef enum logic [1:0] {
		AOS_TRG_SOFT = 2'h0,
		AOS_TRG_RISE = 2'h1,
		AOS_TRG_FALL = 2'h2
	} aos_trg_e;
	typedef struct packed {
		logic       en;
		logic [1:0] code;
		logic       gain;
	} aos_entry_s;
	typedef struct packed {
		logic [15:0] chan_zero;
		logic [15:0] chan_one;
		logic [7:0]  dig;
	} aos_outs_s;
endpackage : aos_pkg

// ---- src/aos_sequencer.sv ----
// Output sequencer with an APB register port, channel list, pacing, triggers and errors.
`timescale 1ns/1ps
`include "aos_defs.svh"
// Summary of operation
// - Converter channels take fixed 16-bit samples; width cannot be changed.
// - Each converter holds a staged value, moved to its output only on a tick.
// - Module reset does not clear the values held by the converters.
// - List code 0 is converter zero, 1 converter one, 2 the digital port.
// - Every list entry runs at a fixed gain of one.
// - All listed channels update together on each tick that starts loading, one sample each.
// - Samples are used in arrival order, consecutive samples to consecutive entries.
// - Each channel sustains 150 kSamples/s, two converters together 300 kSamples/s.
// - The digital port obeys the same pacing, trigger and mode as converters.
// - With software trigger and continuous mode set, the operation starts on the start command.
// - With continuous mode set, external trigger starts on a rising or falling edge by chosen polarity.
// - Internal pacing ticks at a programmed rate from about 0.012 S/s to 150 kS/s.
// - External pacing ticks on rising edges of the external clock input.
// - A tick outside loading with fewer queued samples than listed entries flags underflow; outputs keep their values.
// - A tick during loading of previous values flags an over-sample error.
// - Samples are offset binary: all zeros negative, all ones positive full scale.
module aos_sequencer
	import aos_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        ext_trigger,
	input  wire logic        ext_clock,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic      [15:0] converter_channel_zero,
	output logic      [15:0] converter_channel_one,
	output logic      [7:0]  dig_out
);
	logic        cont_mode;
	logic        ext_pacing;
	aos_trg_e    trg_sel;
	aos_entry_s  list [3];
	logic [31:0] div_val;
	logic [31:0] div_cnt;
	logic        running;
	logic        armed;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [15:0] queue [`AOS_QDEPTH];
	logic [1:0]  wr_ptr;
	logic [1:0]  rd_ptr;
	logic [2:0]  q_count;
	aos_outs_s   stage;
	aos_outs_s   next_stage;
	logic [1:0]  load_idx;
	logic        loading;
	logic [2:0]  trg_sync;
	logic [2:0]  clk_sync;
	logic        trg_rise;
	logic        trg_fall;
	logic        clk_rise;
	logic        int_tick;
	logic        tick;
	logic        start_ev;
	logic        wr_en;
	logic        rd_en;
	logic        push;
	logic        pop;
	logic [1:0]  n_listed;
	logic [31:0] div_eff;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	// The first stage feeds only the second, edge logic looks at stages two and three.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trg_sync <= 3'h0;
			clk_sync <= 3'h0;
		end else begin
			trg_sync <= {trg_sync[1:0], ext_trigger};
			clk_sync <= {clk_sync[1:0], ext_clock};
		end
	end
	assign trg_rise = trg_sync[1] && !trg_sync[2];
	assign trg_fall = !trg_sync[1] && trg_sync[2];
	assign clk_rise = clk_sync[1] && !clk_sync[2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cont_mode <= 1'b0;
			ext_pacing <= 1'b0;
			trg_sel <= AOS_TRG_SOFT;
			div_val <= `AOS_DIV_RESET;
			mask <= 2'h0;
			for (int i = 0; i < 3; i++) begin
				list[i] <= '0;
			end
		end else if (wr_en) begin
			unique case (paddr)
				`AOS_OFF_CTRL: begin
					cont_mode <= pwdata[`AOS_CTRL_CONT];
					ext_pacing <= pwdata[`AOS_CTRL_EXTCLK];
					trg_sel <= aos_trg_e'(pwdata[`AOS_CTRL_TRG_HI:`AOS_CTRL_TRG_LO]);
				end
				`AOS_OFF_LIST: begin
					for (int i = 0; i < 3; i++) begin
						list[i].en <= pwdata[4*i+3];
						list[i].code <= pwdata[4*i+1 -: 2];
						list[i].gain <= 1'b1;
					end
				end
				`AOS_OFF_DIV: div_val <= pwdata;
				`AOS_OFF_MASK: mask <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Faster than the converters allow is clamped, so no software value exceeds the rate.
	assign div_eff = (div_val < `AOS_MIN_DIV) ? `AOS_MIN_DIV : div_val;

	assign start_ev = (trg_sel == AOS_TRG_SOFT) ? (wr_en && paddr == `AOS_OFF_CMD && pwdata[`AOS_CMD_START])
		: (trg_sel == AOS_TRG_RISE) ? trg_rise : (trg_sel == AOS_TRG_FALL) ? trg_fall : 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
			armed <= 1'b0;
		end else if (wr_en && paddr == `AOS_OFF_CMD && pwdata[`AOS_CMD_STOP]) begin
			running <= 1'b0;
			armed <= 1'b0;
		end else if (!running && start_ev && cont_mode) begin
			running <= 1'b1;
			armed <= 1'b1;
		end else if (armed) begin
			armed <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 32'h0;
			int_tick <= 1'b0;
		end else if (!running || ext_pacing) begin
			div_cnt <= 32'h0;
			int_tick <= 1'b0;
		end else if (armed || div_cnt >= div_eff - 32'h1) begin
			div_cnt <= 32'h0;
			int_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 32'h1;
			int_tick <= 1'b0;
		end
	end
	// External pacing starts at the first rising edge after the armed cycle that follows the start event.
	assign tick = running && !armed && (ext_pacing ? clk_rise : int_tick);

	always_comb begin
		n_listed = 2'h0;
		for (int i = 0; i < 3; i++) begin
			n_listed = n_listed + {1'b0, list[i].en};
		end
	end

	assign push = wr_en && paddr == `AOS_OFF_DATA && q_count != 3'(`AOS_QDEPTH);
	// Only listed entries take a sample, so an omitted channel never swallows one.
	assign pop = loading && list[load_idx].en && q_count != 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= 2'h0;
			rd_ptr <= 2'h0;
			q_count <= 3'h0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 2'h1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 2'h1;
			end
			q_count <= q_count + {2'h0, push} - {2'h0, pop};
		end
	end

	always_ff @(posedge pclk) begin
		if (push) begin
			queue[wr_ptr] <= pwdata[15:0];
		end
	end

	// Loading walks the list one entry per cycle into the staging registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loading <= 1'b0;
			load_idx <= 2'h0;
		end else if (tick && !loading && n_listed != 2'h0 && q_count >= {1'b0, n_listed}) begin
			loading <= 1'b1;
			load_idx <= 2'h0;
		end else if (loading) begin
			if (load_idx == 2'h2) begin
				loading <= 1'b0;
			end
			load_idx <= load_idx + 2'h1;
		end
	end

	// Staging and converter registers carry no reset, so a module reset keeps them.
	// The last entry's sample is taken from the next value, so every listed output moves together.
	always_comb begin
		next_stage = stage;
		if (loading && list[load_idx].en && q_count != 3'h0) begin
			unique case (list[load_idx].code)
				`AOS_CH_ZERO: next_stage.chan_zero = queue[rd_ptr];
				`AOS_CH_ONE: next_stage.chan_one = queue[rd_ptr];
				`AOS_CH_DIG: next_stage.dig = queue[rd_ptr][7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk) begin
		stage <= next_stage;
		if (loading && load_idx == 2'h2) begin
			converter_channel_zero <= next_stage.chan_zero;
			converter_channel_one <= next_stage.chan_one;
			dig_out <= next_stage.dig;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 2'h0;
		end else begin
			if (rd_en && paddr == `AOS_OFF_STAT) begin
				status <= 2'h0;
			end
			if (tick && !loading && q_count < {1'b0, n_listed}) begin
				status[`AOS_ST_UNDER] <= 1'b1;
			end
			if (tick && loading) begin
				status[`AOS_ST_OVERS] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable) begin
				unique case (paddr)
					`AOS_OFF_CTRL: prdata <= {28'h0, trg_sel, ext_pacing, cont_mode};
					`AOS_OFF_LIST: prdata <= {20'h0, list[2].en, 1'b0, list[2].code, list[1].en, 1'b0,
						list[1].code, list[0].en, 1'b0, list[0].code};
					`AOS_OFF_DIV: prdata <= div_val;
					`AOS_OFF_STAT: prdata <= {29'h0, running, status};
					`AOS_OFF_MASK: prdata <= {30'h0, mask};
					`AOS_OFF_OUT: prdata <= {converter_channel_one, converter_channel_zero};
					`AOS_OFF_DATA, `AOS_OFF_CMD: prdata <= 32'h0;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule : aos_sequencer

// ---- bench/aos_seq_chk_assertions.sv ----
// Port checker of the output sequencer.
`timescale 1ns/1ps
module aos_seq_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        ext_trigger,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic [15:0] converter_channel_zero,
	input wire logic [15:0] converter_channel_one,
	input wire logic [7:0]  dig_out
);
	logic       ran;
	logic       armed;
	wire        wr = psel && penable && pwrite;
	wire [39:0] outs = {converter_channel_zero, converter_channel_one, dig_out};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Left unreset so that it still sees a later reset.
	always_ff @(posedge pclk) if (presetn) ran <= 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) armed <= 1'b0;
		else if ((wr && paddr == 12'h018) || $changed(ext_trigger)) armed <= 1'b1;
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready in access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_idle: assert property (!psel |=> !pready)
		else $error("pready without request");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h01c |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (pready && paddr <= 12'h01c |-> !pslverr)
		else $error("mapped access refused");
	a_outs_keep_reset: assert property (@(posedge pclk) disable iff (1'b0) ran && !presetn |=> outs === $past(outs))
		else $error("outputs changed in reset");
	a_quiet_unarmed: assert property (!armed |=> outs === $past(outs))
		else $error("outputs moved before start");
	a_irq_unarmed: assert property (!armed |-> !irq)
		else $error("irq before start");
endmodule : aos_seq_chk
bind aos_sequencer aos_seq_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .ext_trigger, .pready,
	.pslverr, .irq, .converter_channel_zero, .converter_channel_one, .dig_out);

// ---- bench/aos_ext_src.sv ----
// Model of the external trigger and pacing clock sources.
`timescale 1ns/1ps
module aos_ext_src (
	input  wire logic pclk,
	output logic      ext_trigger = 1'b0,
	output logic      ext_clock = 1'b0
);
	task trig(input logic v);
		@(posedge pclk) ext_trigger <= v;
	endtask : trig
	// Held for several cycles so the synchroniser cannot miss it.
	task pace();
		@(posedge pclk) ext_clock <= 1'b1;
		repeat (4) @(posedge pclk);
		ext_clock <= 1'b0;
	endtask : pace
endmodule : aos_ext_src

// ---- bench/aos_sequencer_tb_top.sv ----
// Self-checking testbench of the output sequencer.
`timescale 1ns/1ps
`include "aos_defs.svh"
module aos_sequencer_tb_top
	import aos_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd, prdata;
	logic        er, pready, pslverr, irq, ext_trigger, ext_clock;
	logic [15:0] ch0, ch1;
	logic [7:0]  dig;
	aos_outs_s   ex;
	int          n_mismatch = 0;
	int          num_checks = 0;
	always #10 pclk = ~pclk;
	aos_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .ext_trigger, .ext_clock,
		.prdata, .pready, .pslverr, .irq, .converter_channel_zero(ch0), .converter_channel_one(ch1), .dig_out(dig));
	aos_ext_src src_u (.pclk, .ext_trigger, .ext_clock);
	task close_out(input int t);
		n_mismatch += t;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task chk(input logic [39:0] s, input logic [39:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) close_out(1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wait_out(input int lim);
		int k;
		for (k = 0; k < lim && ch0 !== ex.chan_zero; k++) @(posedge pclk);
		if (k >= lim) close_out(1);
		chk({ch0, ch1, dig}, ex);
	endtask : wait_out
	function automatic logic [31:0] ent(input int i, input logic [1:0] c);
		return {28'h0, 2'b10, c} << (4 * i);
	endfunction : ent
	initial begin
		logic [15:0] s [6];
		int          k;
		void'($urandom(32'h5783));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `AOS_OFF_DIV, 0);
		chk(rd, `AOS_DIV_RESET);
		apb(0, 12'h020, 0);
		chk(er, 1'b1);
		apb(1, `AOS_OFF_MASK, 32'h1);
		apb(1, `AOS_OFF_CTRL, 32'h1);
		apb(1, `AOS_OFF_LIST, ent(0, `AOS_CH_ZERO) | ent(1, `AOS_CH_ONE) | ent(2, `AOS_CH_DIG));
		for (int i = 0; i < 6; i++) s[i] = (i == 3) ? 16'hffff : (i == 4) ? 16'h0000 : 16'($urandom());
		for (int i = 0; i < 3; i++) apb(1, `AOS_OFF_DATA, {16'h0, s[i]});
		apb(1, `AOS_OFF_CMD, 32'h1);
		ex = '{s[0], s[1], s[2][7:0]};
		wait_out(40);
		for (int i = 3; i < 6; i++) apb(1, `AOS_OFF_DATA, {16'h0, s[i]});
		ex = '{s[3], s[4], s[5][7:0]};
		wait_out(400);
		for (k = 0; k < 800 && irq !== 1'b1; k++) @(posedge pclk);
		if (k >= 800) close_out(1);
		apb(0, `AOS_OFF_STAT, 0);
		chk(rd[2:0], 3'h5);
		chk({ch0, ch1, dig}, ex);
		apb(0, `AOS_OFF_STAT, 0);
		chk({rd[0], irq}, 2'b00);
		apb(1, `AOS_OFF_CMD, 32'h2);
		apb(1, `AOS_OFF_LIST, ent(0, `AOS_CH_ZERO) | ent(1, `AOS_CH_DIG));
		for (int m = 1; m < 3; m++) begin
			apb(1, `AOS_OFF_CTRL, {28'h0, 2'(m), 2'b11});
			s[0] = 16'($urandom());
			s[1] = 16'($urandom());
			apb(1, `AOS_OFF_DATA, {16'h0, s[0]});
			apb(1, `AOS_OFF_DATA, {16'h0, s[1]});
			src_u.trig(m == 1);
			repeat (8) @(posedge pclk);
			src_u.pace();
			ex = '{s[0], ex.chan_one, s[1][7:0]};
			wait_out(40);
			apb(1, `AOS_OFF_CMD, 32'h2);
		end
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk({ch0, ch1, dig}, ex);
		apb(0, `AOS_OFF_OUT, 0);
		chk(rd, {ex.chan_one, ex.chan_zero});
		close_out(0);
	end
endmodule : aos_sequencer_tb_top
